// *** bench/scb_host_model.sv ***
// smbus host controller model, open-drain data, drives the bus clock
`timescale 1ns/1ns
module scb_host_model (
   input  wire logic       core_clk_in,
   input  wire logic       sda_line_in,
   output logic            scl_out,
   output logic            sda_pull_out,
   output logic            res_stb_out,
   output logic [8:0]      res_out
);
   localparam int HALF = 20;
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
      res_stb_out = 1'b0;
      res_out = 9'h000;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask
   // start and repeated start alike
   task automatic start();
      sda_pull_out = 1'b0;
      hw(HALF);
      scl_out = 1'b1;
      hw(HALF);
      sda_pull_out = 1'b1;
      hw(HALF);
      scl_out = 1'b0;
      hw(2);
   endtask
   task automatic stop();
      sda_pull_out = 1'b1;
      hw(HALF);
      scl_out = 1'b1;
      hw(HALF);
      sda_pull_out = 1'b0;
      hw(HALF);
   endtask
   // data only moves with clock low, or it reads as start/stop
   task automatic bx(input logic b, output logic s);
      sda_pull_out = ~b;
      hw(HALF);
      scl_out = 1'b1;
      hw(HALF / 2);
      s = sda_line_in;
      hw(HALF / 2);
      scl_out = 1'b0;
      hw(2);
   endtask
   // reports {acked, 00} for writes, {0, data} for reads
   task automatic xfer(input logic [7:0] wd, input logic last, input logic rd);
      logic [7:0] d;
      logic a;
      for (int i = 7; i >= 0; i--) bx(rd | wd[i], d[i]);
      bx(rd ? last : 1'b1, a);
      res_out = rd ? {1'b0, d} : {~a, 8'h00};
      res_stb_out = 1'b1;
      hw(1);
      res_stb_out = 1'b0;
   endtask
endmodule

// *** bench/scb_monitor.sv ***
// port assertions for the smbus configuration target
`timescale 1ns/1ns
module scb_monitor (
   input wire logic       core_clk_in,
   input wire logic       srst_in,
   input wire logic       warm_rst_in,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_out,
   input wire logic [1:0] pll_bandwidth_strap_in,
   input wire logic       frequency_select_strap_in,
   input wire logic [7:0] oe_pin_n_in,
   input wire logic [1:0] pll_mode_out,
   input wire logic       frequency_select_out,
   input wire logic [7:0] differential_clock_output_en_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("data line driven high");
   enable_pin_a: assert property ((differential_clock_output_en_out & oe_pin_n_in) == 8'h00)
      else $error("output runs with its pin off");
   mode_hold_a: assert property ((!warm_rst_in) [*3] |-> $stable(pll_mode_out))
      else $error("pll mode moved without warm reset");
   freq_hold_a: assert property (!$past(srst_in) |-> $stable(frequency_select_out))
      else $error("frequency select moved after reset");
   drive_low_scl_a: assert property ($rose(sda_oe_out) |-> !scl_in)
      else $error("data driven while clock high");
   scl_high_still_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
      else $error("data changed while clock high");
   stop_release_a: assert property (scl_in && $rose(sda_in) |=> !sda_oe_out [*4])
      else $error("data line held after stop");
   ack_hold_a: assert property ($rose(sda_oe_out) |=> sda_oe_out [*8])
      else $error("low drive too short");
   cover property ($rose(sda_oe_out));
   cover property ($changed(pll_mode_out));
   cover property (scl_in && $rose(sda_in));
endmodule
bind scb_smbus_target scb_monitor u_mon (.*);

// *** bench/tb_top.sv ***
// self-checking bench for the smbus configuration target
`timescale 1ns/1ns
module tb_top;
   import scb_pkg::*;
   logic       core_clk = 1'b0;
   logic       srst = 1'b1;
   logic       warm = 1'b0;
   logic [7:0] pins, en, bank [9];
   logic [1:0] ps, mode;
   logic       fs, fsel, scl, pull, stb, sda, sda_oe;
   logic [8:0] res, exq [$];
   int         n_errors = 0;
   int         tests_run = 0;
   always #5 core_clk = ~core_clk;
   assign sda = !(pull || sda_oe);
   scb_host_model u_host (.core_clk_in(core_clk), .sda_line_in(sda), .scl_out(scl),
      .sda_pull_out(pull), .res_stb_out(stb), .res_out(res));
   scb_smbus_target DUT (.core_clk_in(core_clk), .srst_in(srst), .warm_rst_in(warm),
      .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
      .pll_bandwidth_strap_in(ps), .frequency_select_strap_in(fs), .oe_pin_n_in(pins),
      .pll_mode_out(mode), .frequency_select_out(fsel),
      .differential_clock_output_en_out(en));
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   always @(posedge stb) chk("reply", exq.size() ? exq.pop_front() : 9'h1ff, res);
   function automatic logic [7:0] msk(input int i);
      case (i)
         0: return 8'h0e;
         1: return 8'hf6;
         2: return 8'h05;
         7: return 8'h1f;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] en_exp();
      return {bank[2][2], bank[2][0], bank[1][7:4], bank[1][2:1]} & ~pins;
   endfunction
   task automatic wr(input logic [7:0] n, input logic [7:0] d[$]);
      repeat (d.size() + 3) exq.push_back(9'h100);
      u_host.start();
      u_host.xfer({SCB_TARGET_ADDR, 1'b0}, 1'b0, 1'b0);
      u_host.xfer(n, 1'b0, 1'b0);
      u_host.xfer(8'(d.size()), 1'b0, 1'b0);
      foreach (d[i]) begin
         u_host.xfer(d[i], 1'b0, 1'b0);
         if (n + i < 9) bank[n + i] = (bank[n + i] & ~msk(n + i)) | (d[i] & msk(n + i));
      end
      u_host.stop();
   endtask
   task automatic rd(input logic [7:0] n);
      int x;
      x = int'(bank[7][4:0]);
      repeat (3) exq.push_back(9'h100);
      exq.push_back({1'b0, bank[7] & 8'h1f});
      for (int i = 0; i < x; i++) exq.push_back({1'b0, (n + i < 9) ? bank[n + i] : 8'h00});
      u_host.start();
      u_host.xfer({SCB_TARGET_ADDR, 1'b0}, 1'b0, 1'b0);
      u_host.xfer(n, 1'b0, 1'b0);
      u_host.start();
      u_host.xfer({SCB_TARGET_ADDR, 1'b1}, 1'b0, 1'b0);
      for (int i = 0; i <= x; i++) u_host.xfer(8'h00, i == x, 1'b1);
      u_host.stop();
   endtask
   task automatic conclude();
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      void'($urandom(86446));
      pins = 8'($urandom);
      ps = 2'($urandom_range(0, 2)) | 2'($urandom_range(0, 1) << 1);
      ps = (ps == 2'h2) ? 2'h3 : ps;
      fs = 1'($urandom);
      repeat (20) @(negedge core_clk);
      srst = 1'b0;
      bank = '{{ps, 5'h03, fs}, 8'hff, 8'h0d, 8'h00, 8'h00, SCB_REV_ID, SCB_DEV_ID, 8'h08, 8'h00};
      repeat (2) @(negedge core_clk);
      chk("pll_mode", 9'(ps), 9'(mode));
      chk("freq_sel", 9'(fs), 9'(fsel));
      chk("enables", 9'(en_exp()), 9'(en));
      rd(8'h00);
      wr(8'h01, '{8'($urandom), 8'($urandom), 8'hff});
      chk("enables", 9'(en_exp()), 9'(en));
      rd(8'h01);
      wr(8'h00, '{8'hff});
      wr(8'h00, '{8'h0a});
      chk("pll_mode", 9'(ps), 9'(mode));
      warm = 1'b1;
      repeat (2) @(negedge core_clk);
      warm = 1'b0;
      chk("pll_mode", 9'(SCB_MODE_BYPASS), 9'(mode));
      rd(8'h00);
      wr(8'h00, '{8'h04});
      warm = 1'b1;
      repeat (2) @(negedge core_clk);
      warm = 1'b0;
      chk("pll_mode", 9'(ps), 9'(mode));
      wr(8'h07, '{8'he3});
      repeat (2) exq.push_back(9'h000);
      u_host.start();
      u_host.xfer({SCB_TARGET_ADDR ^ 7'h01, 1'b0}, 1'b0, 1'b0);
      u_host.xfer(8'h01, 1'b0, 1'b0);
      u_host.stop();
      rd(8'h02);
      pins = ~pins;
      @(negedge core_clk);
      chk("enables", 9'(en_exp()), 9'(en));
      chk("pending", 9'h000, 9'(exq.size()));
      conclude();
   end
   initial begin
      // roughly twice the length of a clean run
      #600000;
      n_errors++;
      conclude();
   end
endmodule

// *** rtl/scb_pkg.sv ***
// constants for the smbus clock buffer configuration target
package scb_pkg;
   localparam logic [6:0] SCB_TARGET_ADDR      = 7'h6c;
   localparam int         SCB_NUM_BYTES        = 9;
   localparam logic [7:0] SCB_IDX_MODE         = 8'h00;
   localparam logic [7:0] SCB_IDX_OE_LOW       = 8'h01;
   localparam logic [7:0] SCB_IDX_OE_HIGH      = 8'h02;
   localparam logic [7:0] SCB_IDX_RSVD3        = 8'h03;
   localparam logic [7:0] SCB_IDX_RSVD4        = 8'h04;
   localparam logic [7:0] SCB_IDX_REV          = 8'h05;
   localparam logic [7:0] SCB_IDX_DEVID        = 8'h06;
   localparam logic [7:0] SCB_IDX_COUNT        = 8'h07;
   localparam logic [7:0] SCB_IDX_RSVD8        = 8'h08;
   // byte 0 fields
   localparam int         SCB_SW_EN_BIT        = 3;
   localparam logic [7:0] SCB_MODE_RW_MASK     = 8'h0e;
   localparam logic [7:0] SCB_MODE_RST         = 8'h06;
   // byte 1, 2 and 7 writable masks and reset images (reserved bits read as default)
   localparam logic [7:0] SCB_OE_LOW_MASK      = 8'hf6;
   localparam logic [7:0] SCB_OE_LOW_RST       = 8'hff;
   localparam logic [7:0] SCB_OE_HIGH_MASK     = 8'h05;
   localparam logic [7:0] SCB_OE_HIGH_RST      = 8'h0d;
   localparam logic [7:0] SCB_COUNT_MASK       = 8'h1f;
   localparam logic [7:0] SCB_COUNT_RST        = 8'h08;
   localparam logic [7:0] SCB_ZERO             = 8'h00;
   // identity bytes: arbitrary neutral values
   localparam logic [7:0] SCB_REV_ID           = 8'h01;
   localparam logic [7:0] SCB_DEV_ID           = 8'h5a;
   // pll mode encodings (read-back bits 7:6)
   localparam logic [1:0] SCB_MODE_LO_BW       = 2'h0;
   localparam logic [1:0] SCB_MODE_BYPASS      = 2'h1;
   localparam logic [1:0] SCB_MODE_HI_BW       = 2'h3;
endpackage

// *** rtl/scb_smbus_target.sv ***
// smbus target with indexed block read/write and configuration byte bank
// Contract
// - index byte acknowledged, becomes first location
// - block write count acknowledged before data
// - ack each write byte; while count remains, store (in-range index only) and advance
// - read returns byte count first
// - then bytes N through N+X-1, per ack
// - host nack plus stop; release data line
// - byte0 bits 7:6 hold strap mode read-only
// - byte0 bit3 override enable, resets zero
// - byte0 bits 2:1 select mode, reset ones
// - override mode applies only after warm reset
// - byte0 bit0 reports frequency strap read-only
// - enable bits force outputs low when zero
// - byte7 count sets read length, default 8
`timescale 1ns/1ns
module scb_smbus_target (
   input  wire logic                core_clk_in,
   input  wire logic                srst_in,
   input  wire logic                warm_rst_in,
   input  wire logic                scl_in,
   input  wire logic                sda_in,
   output logic                     sda_out,
   output logic                     sda_oe_out,
   input  wire logic [1:0]          pll_bandwidth_strap_in,
   input  wire logic                frequency_select_strap_in,
   input  wire logic [7:0]          oe_pin_n_in,
   output logic [1:0]               pll_mode_out,
   output logic                     frequency_select_out,
   output logic [7:0]               differential_clock_output_en_out
);
   import scb_pkg::*;

   typedef enum {ST_IDLE, ST_START, ST_ADDR, ST_ACK,
                 ST_WBYTE, ST_RBYTE, ST_RACK} scb_state_type;

   scb_state_type state_q;
   logic       scl_q, sda_q;
   logic [2:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic [1:0] phase_q;     // 0 index, 1 count, 2 data
   logic       rd_q;        // current transfer is a read
   logic       first_rd_q;  // next read byte is the count
   logic [7:0] idx_q;
   logic [7:0] remain_q;
   logic       ack_drive_q;
   logic [7:0] bank_q [SCB_NUM_BYTES];
   logic [1:0] strap_mode_q;
   logic       strap_freq_q;
   logic [1:0] pll_mode_q;

   wire scl_rise  = scl_in & ~scl_q;
   wire scl_fall  = ~scl_in & scl_q;
   wire start_det = scl_in & scl_q & sda_q & ~sda_in;
   wire stop_det  = scl_in & scl_q & ~sda_q & sda_in;
   wire [7:0] shift_nx = {shift_q[6:0], sda_in};
   wire addr_hit  = (shift_q[7:1] == SCB_TARGET_ADDR);
   wire idx_ok    = (idx_q < 8'(SCB_NUM_BYTES));

   // read image of each byte, reserved fields show their defaults
   wire [7:0] mode_rd = {strap_mode_q, 2'h0, bank_q[0][3:1], strap_freq_q};
   wire [7:0] rd_byte = !idx_ok ? SCB_ZERO :
                        (idx_q == SCB_IDX_MODE)  ? mode_rd :
                        (idx_q == SCB_IDX_REV)   ? SCB_REV_ID :
                        (idx_q == SCB_IDX_DEVID) ? SCB_DEV_ID : bank_q[idx_q[3:0]];

   wire [7:0] wr_mask = (idx_q == SCB_IDX_MODE)    ? SCB_MODE_RW_MASK :
                        (idx_q == SCB_IDX_OE_LOW)  ? SCB_OE_LOW_MASK :
                        (idx_q == SCB_IDX_OE_HIGH) ? SCB_OE_HIGH_MASK :
                        (idx_q == SCB_IDX_COUNT)   ? SCB_COUNT_MASK : SCB_ZERO;

   wire wr_strobe = (state_q == ST_WBYTE) && scl_fall && (bit_cnt_q == 3'h0)
                    && (phase_q == 2'h2) && (remain_q != 8'h0) && idx_ok;

   always_ff @(posedge core_clk_in) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
   end

   // strap capture at reset release, override only on warm reset
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         strap_mode_q <= pll_bandwidth_strap_in;
         strap_freq_q <= frequency_select_strap_in;
         pll_mode_q   <= pll_bandwidth_strap_in;
      end else if (warm_rst_in) begin
         pll_mode_q <= bank_q[0][SCB_SW_EN_BIT] ? bank_q[0][2:1] : strap_mode_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < SCB_NUM_BYTES; g++) begin : g_bank
         localparam logic [7:0] RST = (g == 0) ? SCB_MODE_RST :
                                      (g == 1) ? SCB_OE_LOW_RST :
                                      (g == 2) ? SCB_OE_HIGH_RST :
                                      (g == 7) ? SCB_COUNT_RST : SCB_ZERO;
         always_ff @(posedge core_clk_in) begin
            if (srst_in) begin
               bank_q[g] <= RST;
            end else if (wr_strobe && idx_q == 8'(g)) begin
               bank_q[g] <= (bank_q[g] & ~wr_mask) | (shift_q & wr_mask);
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state_q     <= ST_IDLE;
         bit_cnt_q   <= 3'h0;
         shift_q     <= 8'h0;
         phase_q     <= 2'h0;
         rd_q        <= 1'b0;
         first_rd_q  <= 1'b0;
         idx_q       <= 8'h0;
         remain_q    <= 8'h0;
         ack_drive_q <= 1'b0;
      end else if (start_det) begin
         // repeated start keeps the index written before it
         state_q     <= ST_START;
         bit_cnt_q   <= 3'h0;
         ack_drive_q <= 1'b0;
      end else if (stop_det) begin
         state_q     <= ST_IDLE;
         ack_drive_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               ack_drive_q <= 1'b0;
            end
            // the clock fall closing a start is no byte end
            ST_START: begin
               if (scl_fall) begin
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR, ST_WBYTE: begin
               if (scl_rise) begin
                  shift_q   <= shift_nx;
                  bit_cnt_q <= bit_cnt_q + 3'h1;
               end else if (scl_fall && bit_cnt_q == 3'h0) begin
                  if (state_q == ST_ADDR) begin
                     if (addr_hit) begin
                        ack_drive_q <= 1'b1;
                        rd_q        <= shift_q[0];
                        first_rd_q  <= 1'b1;
                        if (!shift_q[0]) begin
                           phase_q <= 2'h0;
                        end
                        state_q <= ST_ACK;
                     end else begin
                        state_q <= ST_IDLE;
                     end
                  end else begin
                     ack_drive_q <= 1'b1;
                     state_q     <= ST_ACK;
                     case (phase_q)
                        2'h0: begin
                           idx_q   <= shift_q;
                           phase_q <= 2'h1;
                        end
                        2'h1: begin
                           remain_q <= shift_q;
                           phase_q  <= 2'h2;
                        end
                        default: begin
                           if (remain_q != 8'h0) begin
                              remain_q <= remain_q - 8'h1;
                              idx_q    <= idx_q + 8'h1;
                           end
                        end
                     endcase
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  ack_drive_q <= 1'b0;
                  bit_cnt_q   <= 3'h0;
                  if (rd_q) begin
                     shift_q    <= first_rd_q ? bank_q[7] & SCB_COUNT_MASK : rd_byte;
                     first_rd_q <= 1'b0;
                     if (!first_rd_q) begin
                        idx_q <= idx_q + 8'h1;
                     end
                     state_q <= ST_RBYTE;
                  end else begin
                     state_q <= ST_WBYTE;
                  end
               end
            end
            ST_RBYTE: begin
               if (scl_fall) begin
                  shift_q   <= {shift_q[6:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 3'h1;
                  if (bit_cnt_q == 3'h7) begin
                     state_q <= ST_RACK;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  // host nack ends the read and frees the line
                  state_q <= sda_in ? ST_IDLE : ST_ACK;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // drive low only; a high bit releases the open-drain line
   assign sda_out    = 1'b0;
   assign sda_oe_out = ack_drive_q | ((state_q == ST_RBYTE) & ~shift_q[7]);

   assign pll_mode_out         = pll_mode_q;
   assign frequency_select_out = strap_freq_q;
   wire [7:0] reg_en = {bank_q[2][2], bank_q[2][0], bank_q[1][7:4], bank_q[1][2:1]};
   assign differential_clock_output_en_out = reg_en & ~oe_pin_n_in;
endmodule
